// ==== core/mdw_monitor.sv ====
// Warning monitor of a motor driver: threshold compare, warning output, history, alarms.
// Assumes measurements and other pins arrive on the core clock; only the alarm clear pin is synchronised.
//
// Function
// - Warning output set when any warning active.
// - Warnings never cut motor current.
// - Warning output clears itself when causes vanish.
// - Ten-entry volatile history, newest first.
// - Master reads history via monitor access.
// - Maintenance clear empties the history.
// - Power-up reset leaves history empty.
// - Current on, deviation over limit: code 10h.
// - Current off, auto return, deviation: 12h.
// - Temperature over limit: code 21h.
// - Supply over limit: code 22h.
// - Supply under limit: code 25h.
// - Peak overload lasting configured time: 30h.
// - Speed over limit: code 31h.
// - No battery with backup enabled: 48h.
// - Alarm clears on alarm clear input falling edge.
// - Bad gear resolution: latched alarm, power cycle.
// - Excitation-off alarms cut current; others hold.
`timescale 1ns/1ps
`default_nettype none

module mdw_monitor (
    input  wire logic                        core_clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        current_on_i,
    input  wire logic [mdw_pkg::MEAS_W-1:0]  pos_dev_i,
    input  wire logic [mdw_pkg::MEAS_W-1:0]  temp_i,
    input  wire logic [mdw_pkg::MEAS_W-1:0]  volt_i,
    input  wire logic [mdw_pkg::MEAS_W-1:0]  speed_i,
    input  wire logic                        peak_load_i,
    input  wire logic                        battery_ok_i,
    input  wire logic                        alarm_req_i,
    input  wire logic                        alarm_clear_input_i,
    input  wire logic [mdw_pkg::ADDR_W-1:0]  reg_addr_i,
    input  wire logic [mdw_pkg::DATA_W-1:0]  reg_wdata_i,
    input  wire logic                        reg_wr_i,
    input  wire logic                        reg_rd_i,
    output logic      [mdw_pkg::DATA_W-1:0]  reg_rdata_o,
    output logic                             warning_output_o,
    output logic                             motor_enable_o,
    output logic                             alarm_o,
    output logic                             irq_o
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef logic [mdw_pkg::CODE_W-1:0] mdw_code_t;
    typedef logic [mdw_pkg::MEAS_W-1:0] mdw_meas_t;

    typedef struct packed {
        logic [1:0]                        clr_sync;
        logic                              clr_prev;
        mdw_meas_t                         th_dev_on;
        mdw_meas_t                         th_dev_off;
        mdw_meas_t                         th_heat;
        mdw_meas_t                         th_ovolt;
        mdw_meas_t                         th_uvolt;
        mdw_meas_t                         th_load_t;
        mdw_meas_t                         th_speed;
        mdw_meas_t                         gear;
        logic [1:0]                        config_bits;
        mdw_meas_t                         load_cnt;
        logic [mdw_pkg::NUM_WARN-1:0]      warn_prev;
        mdw_code_t [mdw_pkg::HIST_DEPTH-1:0] hist;
        logic [3:0]                        hist_cnt;
        logic                              warn;
        logic                              alarm;
        logic                              gear_alarm;
        logic                              motor_en;
        logic [mdw_pkg::IRQ_W-1:0]         irq_stat;
        logic [mdw_pkg::IRQ_W-1:0]         irq_mask;
        logic                              irq;
        logic [mdw_pkg::DATA_W-1:0]        rdata;
    } mdw_state_s;

    mdw_state_s state_reg;
    mdw_state_s state_next;

    // Priority encoder turning the lowest new source into its code.
    function automatic mdw_code_t mdw_code_of(input logic [mdw_pkg::NUM_WARN-1:0] src);
        mdw_code_t c;
        c = '0;
        if (src[mdw_pkg::W_BATTERY])  c = mdw_pkg::CODE_BATTERY;
        if (src[mdw_pkg::W_OVERSPD])  c = mdw_pkg::CODE_OVERSPD;
        if (src[mdw_pkg::W_OVERLOAD]) c = mdw_pkg::CODE_OVERLOAD;
        if (src[mdw_pkg::W_UNDERVLT]) c = mdw_pkg::CODE_UNDERVLT;
        if (src[mdw_pkg::W_OVERVOLT]) c = mdw_pkg::CODE_OVERVOLT;
        if (src[mdw_pkg::W_OVERHEAT]) c = mdw_pkg::CODE_OVERHEAT;
        if (src[mdw_pkg::W_DEV_OFF])  c = mdw_pkg::CODE_DEV_OFF;
        if (src[mdw_pkg::W_DEV_ON])   c = mdw_pkg::CODE_DEV_ON;
        return c;
    endfunction : mdw_code_of

    function automatic logic [mdw_pkg::DATA_W-1:0] mdw_ext(input mdw_meas_t v);
        return {{(mdw_pkg::DATA_W-mdw_pkg::MEAS_W){1'b0}}, v};
    endfunction : mdw_ext

    // ----------------------------------------------------------------
    // Warning detection
    // ----------------------------------------------------------------
    logic [mdw_pkg::NUM_WARN-1:0] warn_src;
    logic [mdw_pkg::NUM_WARN-1:0] warn_rise;
    logic                         gear_bad;
    logic                         clr_fall;
    logic [mdw_pkg::HIST_DEPTH-1:0] hist_hit;

    always_comb begin
        warn_src = '0;
        warn_src[mdw_pkg::W_DEV_ON]   = current_on_i && (pos_dev_i > state_reg.th_dev_on);
        warn_src[mdw_pkg::W_DEV_OFF]  = !current_on_i
                                        && state_reg.config_bits[mdw_pkg::CFG_AUTO_RET]
                                        && (pos_dev_i > state_reg.th_dev_off);
        warn_src[mdw_pkg::W_OVERHEAT] = temp_i > state_reg.th_heat;
        warn_src[mdw_pkg::W_OVERVOLT] = volt_i > state_reg.th_ovolt;
        warn_src[mdw_pkg::W_UNDERVLT] = volt_i < state_reg.th_uvolt;
        warn_src[mdw_pkg::W_OVERLOAD] = peak_load_i
                                        && (state_reg.load_cnt >= state_reg.th_load_t);
        warn_src[mdw_pkg::W_OVERSPD]  = speed_i > state_reg.th_speed;
        warn_src[mdw_pkg::W_BATTERY]  = !battery_ok_i
                                        && state_reg.config_bits[mdw_pkg::CFG_ABS_BKUP];
        warn_rise = warn_src & ~state_reg.warn_prev;
        gear_bad  = (state_reg.gear < mdw_pkg::GEAR_MIN) || (state_reg.gear > mdw_pkg::GEAR_MAX);
        clr_fall  = state_reg.clr_prev && !state_reg.clr_sync[1];
    end

    // History slot decode for reads.
    genvar gi;
    generate
        for (gi = 0; gi < mdw_pkg::HIST_DEPTH; gi++) begin : g_hit
            assign hist_hit[gi] = reg_addr_i == 8'(mdw_pkg::OFS_HIST_BASE + 4 * gi);
        end
    endgenerate

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        state_next.clr_sync = {state_reg.clr_sync[0], alarm_clear_input_i};
        state_next.clr_prev = state_reg.clr_sync[1];
        state_next.warn_prev = warn_src;

        // Overload duration counter saturates so a long load never wraps back.
        if (!peak_load_i) begin
            state_next.load_cnt = '0;
        end else if (state_reg.load_cnt != '1) begin
            state_next.load_cnt = state_reg.load_cnt + 1'b1;
        end

        state_next.warn = |warn_src;

        // Several sources rising together log only the highest-priority one.
        if (|warn_rise) begin
            for (int i = mdw_pkg::HIST_DEPTH - 1; i > 0; i--) begin
                state_next.hist[i] = state_reg.hist[i-1];
            end
            state_next.hist[0] = mdw_code_of(warn_rise);
            if (state_reg.hist_cnt != 4'(mdw_pkg::HIST_DEPTH)) begin
                state_next.hist_cnt = state_reg.hist_cnt + 1'b1;
            end
        end

        // Latched until reset, so a corrected gear value still needs a power cycle.
        if (gear_bad) begin
            state_next.gear_alarm = 1'b1;
        end

        if (alarm_req_i) begin
            state_next.alarm = 1'b1;
        end else if (clr_fall) begin
            state_next.alarm = 1'b0;
        end

        // Only the gear alarm is classed excitation off here.
        state_next.motor_en = !state_reg.gear_alarm;

        state_next.rdata = '0;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                mdw_pkg::OFS_IRQ_STAT:  state_next.irq_stat = state_reg.irq_stat
                                            & ~reg_wdata_i[mdw_pkg::IRQ_W-1:0];
                mdw_pkg::OFS_IRQ_MASK:  state_next.irq_mask = reg_wdata_i[mdw_pkg::IRQ_W-1:0];
                mdw_pkg::OFS_HIST_CLR: begin
                    if (reg_wdata_i[0]) begin
                        state_next.hist_cnt = '0;
                        state_next.hist     = '0;
                    end
                end
                mdw_pkg::OFS_TH_DEV_ON: state_next.th_dev_on  = reg_wdata_i[mdw_pkg::MEAS_W-1:0];
                mdw_pkg::OFS_TH_DEV_OF: state_next.th_dev_off = reg_wdata_i[mdw_pkg::MEAS_W-1:0];
                mdw_pkg::OFS_TH_HEAT:   state_next.th_heat    = reg_wdata_i[mdw_pkg::MEAS_W-1:0];
                mdw_pkg::OFS_TH_OVOLT:  state_next.th_ovolt   = reg_wdata_i[mdw_pkg::MEAS_W-1:0];
                mdw_pkg::OFS_TH_UVOLT:  state_next.th_uvolt   = reg_wdata_i[mdw_pkg::MEAS_W-1:0];
                mdw_pkg::OFS_TH_LOAD_T: state_next.th_load_t  = reg_wdata_i[mdw_pkg::MEAS_W-1:0];
                mdw_pkg::OFS_TH_SPEED:  state_next.th_speed   = reg_wdata_i[mdw_pkg::MEAS_W-1:0];
                mdw_pkg::OFS_CONFIG:    state_next.config_bits = reg_wdata_i[1:0];
                mdw_pkg::OFS_GEAR:      state_next.gear       = reg_wdata_i[mdw_pkg::MEAS_W-1:0];
                default: ;
            endcase
        end

        if (reg_rd_i) begin
            unique case (reg_addr_i)
                mdw_pkg::OFS_STATUS: begin
                    state_next.rdata[mdw_pkg::ST_WARN]  = state_reg.warn;
                    state_next.rdata[mdw_pkg::ST_MOTOR] = state_reg.motor_en;
                    state_next.rdata[mdw_pkg::ST_ALARM] = state_reg.alarm;
                    state_next.rdata[mdw_pkg::ST_GEAR]  = state_reg.gear_alarm;
                end
                mdw_pkg::OFS_IRQ_STAT:  state_next.rdata[mdw_pkg::IRQ_W-1:0] = state_reg.irq_stat;
                mdw_pkg::OFS_IRQ_MASK:  state_next.rdata[mdw_pkg::IRQ_W-1:0] = state_reg.irq_mask;
                mdw_pkg::OFS_HIST_CNT:  state_next.rdata[3:0] = state_reg.hist_cnt;
                mdw_pkg::OFS_TH_DEV_ON: state_next.rdata = mdw_ext(state_reg.th_dev_on);
                mdw_pkg::OFS_TH_DEV_OF: state_next.rdata = mdw_ext(state_reg.th_dev_off);
                mdw_pkg::OFS_TH_HEAT:   state_next.rdata = mdw_ext(state_reg.th_heat);
                mdw_pkg::OFS_TH_OVOLT:  state_next.rdata = mdw_ext(state_reg.th_ovolt);
                mdw_pkg::OFS_TH_UVOLT:  state_next.rdata = mdw_ext(state_reg.th_uvolt);
                mdw_pkg::OFS_TH_LOAD_T: state_next.rdata = mdw_ext(state_reg.th_load_t);
                mdw_pkg::OFS_TH_SPEED:  state_next.rdata = mdw_ext(state_reg.th_speed);
                mdw_pkg::OFS_CONFIG:    state_next.rdata[1:0] = state_reg.config_bits;
                mdw_pkg::OFS_GEAR:      state_next.rdata = mdw_ext(state_reg.gear);
                default: begin
                    for (int i = 0; i < mdw_pkg::HIST_DEPTH; i++) begin
                        if (hist_hit[i]) begin
                            state_next.rdata[mdw_pkg::CODE_W-1:0] = state_reg.hist[i];
                        end
                    end
                end
            endcase
        end

        // Hardware set is applied after the software clear so a same-cycle event survives.
        if (|warn_rise) begin
            state_next.irq_stat[mdw_pkg::IRQ_WARN_NEW] = 1'b1;
        end
        if (gear_bad && !state_reg.gear_alarm) begin
            state_next.irq_stat[mdw_pkg::IRQ_GEAR_ALM] = 1'b1;
        end
        state_next.irq = |(state_next.irq_stat & state_next.irq_mask);
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg              <= '0;
            state_reg.th_dev_on    <= mdw_pkg::RST_THRESH_HI;
            state_reg.th_dev_off   <= mdw_pkg::RST_THRESH_HI;
            state_reg.th_heat      <= mdw_pkg::RST_THRESH_HI;
            state_reg.th_ovolt     <= mdw_pkg::RST_THRESH_HI;
            state_reg.th_uvolt     <= mdw_pkg::RST_THRESH_LO;
            state_reg.th_load_t    <= mdw_pkg::RST_THRESH_HI;
            state_reg.th_speed     <= mdw_pkg::RST_THRESH_HI;
            state_reg.gear         <= mdw_pkg::RST_GEAR;
            state_reg.config_bits  <= mdw_pkg::RST_CONFIG;
            state_reg.irq_mask     <= mdw_pkg::RST_IRQ_MASK;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata_o      = state_reg.rdata;
    assign warning_output_o = state_reg.warn;
    assign motor_enable_o   = state_reg.motor_en;
    assign alarm_o          = state_reg.alarm;
    assign irq_o            = state_reg.irq;

endmodule : mdw_monitor

`default_nettype wire

// ==== core/mdw_pkg.sv ====
// Package for the motor driver warning monitor: codes, widths, offsets, reset values.
// Assumes a single core clock domain and a plain strobe register port.
package mdw_pkg;
    // ----------------------------------------------------------------
    // Widths and sizes
    // ----------------------------------------------------------------
    localparam int unsigned HIST_DEPTH = 10;
    localparam int unsigned CODE_W     = 8;
    localparam int unsigned MEAS_W     = 16;
    localparam int unsigned NUM_WARN   = 8;
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned DATA_W     = 32;

    // ----------------------------------------------------------------
    // Warning codes, one per warning source
    // ----------------------------------------------------------------
    localparam logic [CODE_W-1:0] CODE_DEV_ON   = 8'h10;
    localparam logic [CODE_W-1:0] CODE_DEV_OFF  = 8'h12;
    localparam logic [CODE_W-1:0] CODE_OVERHEAT = 8'h21;
    localparam logic [CODE_W-1:0] CODE_OVERVOLT = 8'h22;
    localparam logic [CODE_W-1:0] CODE_UNDERVLT = 8'h25;
    localparam logic [CODE_W-1:0] CODE_OVERLOAD = 8'h30;
    localparam logic [CODE_W-1:0] CODE_OVERSPD  = 8'h31;
    localparam logic [CODE_W-1:0] CODE_BATTERY  = 8'h48;

    // Warning source bit positions.
    localparam int unsigned W_DEV_ON   = 0;
    localparam int unsigned W_DEV_OFF  = 1;
    localparam int unsigned W_OVERHEAT = 2;
    localparam int unsigned W_OVERVOLT = 3;
    localparam int unsigned W_UNDERVLT = 4;
    localparam int unsigned W_OVERLOAD = 5;
    localparam int unsigned W_OVERSPD  = 6;
    localparam int unsigned W_BATTERY  = 7;

    // ----------------------------------------------------------------
    // Gear resolution limits in pulses per revolution
    // ----------------------------------------------------------------
    localparam logic [MEAS_W-1:0] GEAR_MIN = 16'h0064;
    localparam logic [MEAS_W-1:0] GEAR_MAX = 16'h2710;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_HIST_CNT  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_HIST_CLR  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_TH_DEV_ON = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_TH_DEV_OF = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_TH_HEAT   = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_TH_OVOLT  = 8'h20;
    localparam logic [ADDR_W-1:0] OFS_TH_UVOLT  = 8'h24;
    localparam logic [ADDR_W-1:0] OFS_TH_LOAD_T = 8'h28;
    localparam logic [ADDR_W-1:0] OFS_TH_SPEED  = 8'h2c;
    localparam logic [ADDR_W-1:0] OFS_CONFIG    = 8'h30;
    localparam logic [ADDR_W-1:0] OFS_GEAR      = 8'h34;
    localparam logic [ADDR_W-1:0] OFS_HIST_BASE = 8'h40;

    // Config register fields.
    localparam int unsigned CFG_AUTO_RET = 0;
    localparam int unsigned CFG_ABS_BKUP = 1;

    // Status register fields.
    localparam int unsigned ST_WARN   = 0;
    localparam int unsigned ST_MOTOR  = 1;
    localparam int unsigned ST_ALARM  = 2;
    localparam int unsigned ST_GEAR   = 3;

    // Interrupt status fields.
    localparam int unsigned IRQ_WARN_NEW = 0;
    localparam int unsigned IRQ_GEAR_ALM = 1;
    localparam int unsigned IRQ_W        = 2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [MEAS_W-1:0] RST_THRESH_HI = 16'hffff;
    localparam logic [MEAS_W-1:0] RST_THRESH_LO = 16'h0000;
    localparam logic [MEAS_W-1:0] RST_GEAR      = 16'h03e8;
    localparam logic [1:0]        RST_CONFIG    = 2'h0;
    localparam logic [IRQ_W-1:0]  RST_IRQ_MASK  = 2'h0;
endpackage : mdw_pkg

// ==== tb/mdw_monitor_sva.sv ====
// Checker: watches the monitor ports, snoops threshold writes.
// Assumes one core clock and the package register map.
`timescale 1ns/1ps
`default_nettype none
module mdw_monitor_sva (
    input wire logic                       core_clk_i,
    input wire logic                       rst_n_i,
    input wire logic                       current_on_i,
    input wire logic [mdw_pkg::MEAS_W-1:0] pos_dev_i,
    input wire logic [mdw_pkg::MEAS_W-1:0] temp_i,
    input wire logic [mdw_pkg::MEAS_W-1:0] volt_i,
    input wire logic                       peak_load_i,
    input wire logic                       alarm_req_i,
    input wire logic                       alarm_clear_input_i,
    input wire logic [mdw_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [mdw_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic                       reg_wr_i,
    input wire logic                       reg_rd_i,
    input wire logic [mdw_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic                       warning_output_o,
    input wire logic                       motor_enable_o,
    input wire logic                       alarm_o
);
    // ----------
    // Shadow thresholds
    // ----------
    // Deviation, heat, over and under voltage, load time.
    logic [4:0][15:0] th_reg;
    logic [15:0]      run_reg;

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            th_reg    <= {5{mdw_pkg::RST_THRESH_HI}};
            th_reg[3] <= mdw_pkg::RST_THRESH_LO;
            run_reg   <= 16'h0000;
        end else begin
            run_reg <= peak_load_i ? run_reg + 16'h0001 : 16'h0000;
            if (reg_wr_i) begin
                case (reg_addr_i)
                    mdw_pkg::OFS_TH_DEV_ON: th_reg[0] <= reg_wdata_i[15:0];
                    mdw_pkg::OFS_TH_HEAT:   th_reg[1] <= reg_wdata_i[15:0];
                    mdw_pkg::OFS_TH_OVOLT:  th_reg[2] <= reg_wdata_i[15:0];
                    mdw_pkg::OFS_TH_UVOLT:  th_reg[3] <= reg_wdata_i[15:0];
                    mdw_pkg::OFS_TH_LOAD_T: th_reg[4] <= reg_wdata_i[15:0];
                    default: ;
                endcase
            end
        end
    end

    // ----------
    // Assertions
    // ----------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_DEV_ON: assert property (current_on_i && pos_dev_i > th_reg[0]
        |=> warning_output_o) else $error("deviation warning missing");
    AST_HEAT: assert property (temp_i > th_reg[1] |=> warning_output_o)
        else $error("overheat warning missing");
    AST_OVOLT: assert property (volt_i > th_reg[2] |=> warning_output_o)
        else $error("overvoltage warning missing");
    AST_UVOLT: assert property (volt_i < th_reg[3] |=> warning_output_o)
        else $error("undervoltage warning missing");
    AST_OVLD: assert property (peak_load_i && run_reg >= th_reg[4] |=> warning_output_o)
        else $error("overload warning missing");
    AST_RDATA_IDLE: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("read data outside its cycle");
    AST_ALM_SET: assert property (alarm_req_i |=> alarm_o)
        else $error("alarm not raised");
    AST_ALM_CLR: assert property ($fell(alarm_clear_input_i)
        ##0 (!alarm_req_i)[*6] |=> !alarm_o) else $error("alarm not cleared by pin fall");
    AST_NO_CUT: assert property (motor_enable_o |=> motor_enable_o
        || $past(reg_wr_i && reg_addr_i == mdw_pkg::OFS_GEAR, 3))
        else $error("motor current cut without gear alarm");

    COV_CLR: cover property ($fell(alarm_o));
    COV_OVLD: cover property (peak_load_i && run_reg >= th_reg[4]);
    COV_READ: cover property (reg_rd_i ##1 reg_rdata_o != 32'h0);
endmodule : mdw_monitor_sva

bind mdw_monitor mdw_monitor_sva u_sva (.*);
`default_nettype wire

// ==== tb/mdw_master.sv ====
// Master controller model: issues monitor reads and maintenance writes.
// Assumes a slave that never waits and answers a read in the next cycle.
`timescale 1ns/1ps
`default_nettype none
module mdw_master (
    input  wire logic                       core_clk_i,
    output logic      [mdw_pkg::ADDR_W-1:0] reg_addr_o,
    output logic      [mdw_pkg::DATA_W-1:0] reg_wdata_o,
    output logic                            reg_wr_o,
    output logic                            reg_rd_o
);
    initial {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = 42'h0;

    // Address and data are inverted once released, so nothing may lean on stale values.
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        reg_wr_o    <= wr;
        reg_rd_o    <= !wr;
        @(posedge core_clk_i);
        reg_addr_o  <= ~a;
        reg_wdata_o <= ~d;
        reg_wr_o    <= 1'b0;
        reg_rd_o    <= 1'b0;
    endtask : access
endmodule : mdw_master
`default_nettype wire

// ==== tb/tb.sv ====
// Testbench: drives measurements and pins, registers via the master model.
// Assumes the package, design, master model and bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module tb;
    typedef struct {logic [31:0] v; string n;} mdw_note_s;
    localparam logic [7:0] CODES [8] = '{mdw_pkg::CODE_DEV_ON, mdw_pkg::CODE_DEV_OFF,
        mdw_pkg::CODE_OVERHEAT, mdw_pkg::CODE_OVERVOLT, mdw_pkg::CODE_UNDERVLT,
        mdw_pkg::CODE_OVERLOAD, mdw_pkg::CODE_OVERSPD, mdw_pkg::CODE_BATTERY};
    localparam logic [7:0]  TA [8] = '{8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30};
    localparam logic [15:0] TV [8] = '{16'h0064, 16'h0064, 16'h0064, 16'h00c8, 16'h0032,
        16'h0003, 16'h0064, 16'h0003};
    logic        core_clk_i, rst_n_i, current_on_i, peak_load_i, battery_ok_i, rd_q;
    logic        alarm_req_i, alarm_clear_input_i, reg_wr_i, reg_rd_i;
    logic        warning_output_o, motor_enable_o, alarm_o, irq_o;
    logic [15:0] pos_dev_i, temp_i, volt_i, speed_i, rnd;
    logic [7:0]  reg_addr_i;
    logic [31:0] reg_wdata_i, reg_rdata_o;
    mdw_note_s   exp_q[$];
    mdw_note_s   note;
    int          fail_count = 0;
    int          tests_run = 0;
    int          cycles = 0;
    int          seed = 32'hed5d;

    mdw_monitor dut (.*);
    mdw_master u_mst (.core_clk_i(core_clk_i), .reg_addr_o(reg_addr_i),
        .reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i));

    // ----------
    // Shared tasks
    // ----------
    task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
        u_mst.access(1'b0, a, 32'h0000_0000);
        exp_q.push_back('{e, n});
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_mst.access(1'b1, a, d);
    endtask : wr
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : tick
    task automatic cause(input int i, input logic on);
        @(posedge core_clk_i);
        case (i)
            0: pos_dev_i <= on ? 16'hc8 : 16'h0;
            1: begin
                current_on_i <= !on;
                pos_dev_i    <= on ? 16'hc8 : 16'h0;
            end
            2: temp_i <= on ? 16'hc8 : 16'h0;
            3: volt_i <= on ? 16'h12c : 16'h64;
            4: volt_i <= on ? 16'h14 : 16'h64;
            5: peak_load_i <= on;
            6: speed_i <= on ? 16'hc8 : 16'h0;
            default: battery_ok_i <= !on;
        endcase
    endtask : cause
    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : tally_and_finish

    // ----------
    // Read data watcher, clock and timeout
    // ----------
    always @(posedge core_clk_i) begin
        if (rd_q) begin
            note = exp_q.pop_front();
            check(note.n, reg_rdata_o, note.v);
        end
        rd_q <= reg_rd_i;
        cycles++;
        if (cycles == 4000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end

    // ----------
    // Scenarios
    // ----------
    initial begin
        {rst_n_i, rd_q, peak_load_i, alarm_req_i, alarm_clear_input_i} = 5'h0;
        {current_on_i, battery_ok_i} = 2'h3;
        {pos_dev_i, temp_i, speed_i} = 48'h0;
        volt_i = 16'h64;
        repeat (2) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rd(mdw_pkg::OFS_STATUS, 32'h2, "status");
        rd(mdw_pkg::OFS_HIST_CNT, 32'h0, "hist count");
        foreach (TA[k]) wr(TA[k], {16'h0, TV[k]});
        for (int i = 0; i < 8; i++) begin
            cause(i, 1'b1);
            tick(3);
            if (i == 5) check("overload early", warning_output_o, 32'h0);
            tick(3);
            check("warning", warning_output_o, 32'h1);
            check("motor", motor_enable_o, 32'h1);
            rd(8'h40, {24'h0, CODES[i]}, "new");
            cause(i, 1'b0);
            tick(2);
            check("warning", warning_output_o, 32'h0);
        end
        rd(8'h5c, {24'h0, CODES[0]}, "oldest");
        for (int j = 0; j < 3; j++) begin
            cause(2, 1'b1);
            cause(2, 1'b0);
            tick(2);
        end
        rd(mdw_pkg::OFS_HIST_CNT, 32'ha, "hist count");
        rd(8'h64, {24'h0, CODES[1]}, "oldest kept");
        rd(8'h4c, {24'h0, CODES[7]}, "slot 3");
        rd(8'hfc, 32'h0, "unmapped");
        $display("test warnings done");
        tick(1);
        check("irq masked", irq_o, 32'h0);
        wr(mdw_pkg::OFS_IRQ_MASK, 32'h1);
        tick(1);
        check("irq raised", irq_o, 32'h1);
        wr(mdw_pkg::OFS_IRQ_STAT, 32'h1);
        tick(1);
        check("irq cleared", irq_o, 32'h0);
        wr(mdw_pkg::OFS_HIST_CLR, 32'h1);
        rd(mdw_pkg::OFS_HIST_CNT, 32'h0, "hist count");
        $display("test irq and clear done");
        for (int r = 0; r < 8; r++) begin
            @(posedge core_clk_i);
            rnd = 16'($random(seed)) & 16'h00ff;
            temp_i <= rnd;
            tick(1);
            check("warning", warning_output_o, {31'h0, rnd > 16'h64});
        end
        cause(2, 1'b0);
        @(posedge core_clk_i);
        alarm_req_i <= 1'b1;
        @(posedge core_clk_i);
        alarm_req_i <= 1'b0;
        alarm_clear_input_i <= 1'b1;
        tick(1);
        check("alarm", alarm_o, 32'h1);
        check("motor", motor_enable_o, 32'h1);
        @(posedge core_clk_i);
        alarm_clear_input_i <= 1'b0;
        tick(8);
        check("alarm", alarm_o, 32'h0);
        wr(mdw_pkg::OFS_GEAR, 32'h10);
        tick(3);
        check("motor", motor_enable_o, 32'h0);
        @(posedge core_clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        rd(mdw_pkg::OFS_HIST_CNT, 32'h0, "hist after reset");
        tick(2);
        check("motor", motor_enable_o, 32'h1);
        $display("test alarm and power cycle done");
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
